// ===== pmsb_bank.sv
// pmsb_bank: status flags, command registers and default store/restore.
// assumes a decoded command port (code, write/read strobes, data) from
// the bus engine, and fault event pulses from the power stage monitor.
// Operation
// - summary low byte: off, ov, oc, vin uv, temp, comm; others zero
// - output voltage status: ov fault in bit 7 only
// - output current status: oc fault bit 7, oc warning bit 5
// - input status: ov bit 7, uv bit 4, low-input off bit 3
// - temperature status: fault bit 7, warning bit 6
// - comm status: bad command bit 7, bad data bit 6, pec bit 5
// - keep history of last 20 fault events with status and time
// - on/off at 0x01 bit 7, margins bits 5:2, reset on
// - pin config 0x02: bits 3,1 writable, bit 1 polarity strap
// - store defaults 0x11 finishes within 500 ms; host waits
// - restore defaults 0x12 finishes within 200 ms; host waits
// - format register 0x20 read only, returns 0x14
// - codes 0x21, 0x23, 0x25, 0x26 are unsupported
// - droop 0x28 accepts 0 to 50.0 mV/A
// - turn-on 39..46 V, turn-off 32..46 V
// - reject hysteresis under 2 V or off above on
// - ov limit 10.9..15.99 V and above setpoint
// - effective ov limit capped at setpoint plus 3 V, max 15.99 V
// - margin field: 00xx off, 0110 low, 1010 high
// - unsupported status bits never set, read zero
`timescale 1ns/1ps
module pmsb_bank #(
    parameter int STORE_CYCLES = pmsb_pkg::STORE_CYC,
    parameter int RESTORE_CYCLES = pmsb_pkg::RESTORE_CYC,
    parameter int DEPTH = pmsb_pkg::HIST_DEPTH
) (
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic [7:0] cmd_code_in,
    input wire logic cmd_wr_in,
    input wire logic cmd_rd_in,
    input wire logic [15:0] cmd_wdata_in,
    input wire logic pec_err_in,
    input wire logic pol_strap_in,
    input wire logic [15:0] vout_set_in,
    input wire pmsb_pkg::pmsb_events_t events_in,
    input wire logic [31:0] time_in,
    input wire pmsb_pkg::pmsb_params_t nvm_rdata_in,
    input wire logic [4:0] hist_idx_in,
    output logic [15:0] rdata_out,
    output logic rvalid_out,
    output logic busy_out,
    output logic output_on_out,
    output logic [1:0] margin_out,
    output logic [15:0] ov_limit_eff_out,
    output pmsb_pkg::pmsb_params_t nvm_wdata_out,
    output logic nvm_wr_out,
    output logic [47:0] hist_out
);
    typedef enum logic [1:0] {ST_IDLE, ST_STORE, ST_RESTORE} pmsb_st_t;

    function automatic logic in_rng(input logic [15:0] v,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
        in_rng = (v >= lo) && (v <= hi);
    endfunction : in_rng

    pmsb_pkg::pmsb_params_t par_r;
    logic strap_r;
    logic [7:0] st_vout_r, st_iout_r, st_in_r, st_temp_r, st_cml_r;
    logic off_r;
    pmsb_st_t st_r;
    logic [31:0] cnt_r;
    logic [47:0] hist_r [DEPTH];
    logic [4:0] hptr_r;
    logic [15:0] rdata_r;
    logic rvalid_r;
    logic [15:0] ovcap_r;
    logic nvm_wr_r;
    logic first_r;
    logic busy_r;

    // bus decode
    wire is_w = cmd_wr_in && (st_r == ST_IDLE);
    wire is_clear = is_w && cmd_code_in == pmsb_pkg::CMD_CLEAR;
    wire [15:0] d = cmd_wdata_in;
    wire ok_oper = (d[5:4] == 2'b00) || (d[5:2] == pmsb_pkg::MARGIN_LOW)
                   || (d[5:2] == pmsb_pkg::MARGIN_HIGH);
    wire ok_droop = d <= pmsb_pkg::DROOP_MAX;
    wire ok_on = in_rng(d, pmsb_pkg::VINON_MIN, pmsb_pkg::VINON_MAX)
                 && d >= par_r.vin_off + pmsb_pkg::HYST_MIN;
    wire ok_off = in_rng(d, pmsb_pkg::VINOFF_MIN, pmsb_pkg::VINOFF_MAX)
                  && d + pmsb_pkg::HYST_MIN <= par_r.vin_on;
    wire ok_ov = in_rng(d, pmsb_pkg::OV_MIN, pmsb_pkg::OV_MAX)
                 && d > vout_set_in;
    wire known = cmd_code_in inside {pmsb_pkg::CMD_OPER,
        pmsb_pkg::CMD_ONOFF, pmsb_pkg::CMD_CLEAR, pmsb_pkg::CMD_STORE,
        pmsb_pkg::CMD_RESTORE, pmsb_pkg::CMD_DROOP, pmsb_pkg::CMD_VINON,
        pmsb_pkg::CMD_VINOFF, pmsb_pkg::CMD_OVLIM};
    wire rd_known = known || cmd_code_in inside {pmsb_pkg::CMD_FMT,
        pmsb_pkg::CMD_SUMWORD, pmsb_pkg::CMD_ST_VOUT,
        pmsb_pkg::CMD_ST_IOUT, pmsb_pkg::CMD_ST_INPUT,
        pmsb_pkg::CMD_ST_TEMP, pmsb_pkg::CMD_ST_CML};
    wire bad_cmd = (is_w && !known) || (cmd_rd_in && !rd_known);
    wire bad_data = is_w && (
        (cmd_code_in == pmsb_pkg::CMD_OPER && !ok_oper) ||
        (cmd_code_in == pmsb_pkg::CMD_DROOP && !ok_droop) ||
        (cmd_code_in == pmsb_pkg::CMD_VINON && !ok_on) ||
        (cmd_code_in == pmsb_pkg::CMD_VINOFF && !ok_off) ||
        (cmd_code_in == pmsb_pkg::CMD_OVLIM && !ok_ov));
    wire wr_ok = is_w && known && !bad_data;

    // summary low byte derived from latched bytes
    wire [7:0] sum_lo = {1'b0, off_r, st_vout_r[7], st_iout_r[7],
        st_in_r[4], |st_temp_r, |st_cml_r, 1'b0};
    wire any_fault = |{events_in};
    // history entry shows the summary with this cycle's events folded in
    wire [7:0] sum_ev = sum_lo | {2'b00, events_in.ov_out,
        events_in.oc_fault, events_in.vin_uv,
        events_in.ot_fault | events_in.ot_warn, 2'b00};
    wire [15:0] cap_raw = vout_set_in + pmsb_pkg::OV_MARGIN;
    wire cap_ovf = cap_raw < vout_set_in;
    wire [15:0] cap = (cap_ovf || cap_raw > pmsb_pkg::OV_MAX)
                      ? pmsb_pkg::OV_MAX : cap_raw;
    wire [15:0] ov_eff = (par_r.ov_lim > cap) ? cap : par_r.ov_lim;
    wire [7:0] onoff_rd = {par_r.onoff[7:2], strap_r, par_r.onoff[0]};

    logic [15:0] rd_mux;
    always_comb begin
        case (cmd_code_in)
            pmsb_pkg::CMD_OPER: rd_mux = {8'h00, par_r.oper};
            pmsb_pkg::CMD_ONOFF: rd_mux = {8'h00, onoff_rd};
            pmsb_pkg::CMD_FMT: rd_mux = {8'h00, pmsb_pkg::FMT_VAL};
            pmsb_pkg::CMD_DROOP: rd_mux = par_r.droop;
            pmsb_pkg::CMD_VINON: rd_mux = par_r.vin_on;
            pmsb_pkg::CMD_VINOFF: rd_mux = par_r.vin_off;
            pmsb_pkg::CMD_OVLIM: rd_mux = par_r.ov_lim;
            pmsb_pkg::CMD_SUMWORD: rd_mux = {8'h00, sum_lo};
            pmsb_pkg::CMD_ST_VOUT: rd_mux = {8'h00, st_vout_r};
            pmsb_pkg::CMD_ST_IOUT: rd_mux = {8'h00, st_iout_r};
            pmsb_pkg::CMD_ST_INPUT: rd_mux = {8'h00, st_in_r};
            pmsb_pkg::CMD_ST_TEMP: rd_mux = {8'h00, st_temp_r};
            pmsb_pkg::CMD_ST_CML: rd_mux = {8'h00, st_cml_r};
            default: rd_mux = 16'h0000;
        endcase
    end

    // strap caught at the first clocked cycle after reset release
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            first_r <= 1'b1;
            strap_r <= 1'b0;
        end else if (first_r) begin
            first_r <= 1'b0;
            strap_r <= pol_strap_in;
        end
    end

    // parameter registers; write and restore share one path
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            par_r <= '{pmsb_pkg::DROOP_RST, pmsb_pkg::VINON_RST,
                pmsb_pkg::VINOFF_RST, pmsb_pkg::OV_RST,
                pmsb_pkg::OPER_RST, pmsb_pkg::ONOFF_RST};
        end else if (st_r == ST_RESTORE && cnt_r == 32'h0) begin
            par_r <= nvm_rdata_in;
        end else if (wr_ok) begin
            case (cmd_code_in)
                pmsb_pkg::CMD_OPER: par_r.oper <= d[7:0]
                    & pmsb_pkg::OPER_WMASK;
                pmsb_pkg::CMD_ONOFF: par_r.onoff <= (par_r.onoff
                    & ~pmsb_pkg::ONOFF_WMASK)
                    | (d[7:0] & pmsb_pkg::ONOFF_WMASK);
                pmsb_pkg::CMD_DROOP: par_r.droop <= d;
                pmsb_pkg::CMD_VINON: par_r.vin_on <= d;
                pmsb_pkg::CMD_VINOFF: par_r.vin_off <= d;
                pmsb_pkg::CMD_OVLIM: par_r.ov_lim <= d;
                default: par_r <= par_r;
            endcase
        end
    end

    // store / restore sequencer; writes are ignored while busy, reads are still served
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            st_r <= ST_IDLE;
            cnt_r <= 32'h0;
            nvm_wr_r <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            nvm_wr_r <= 1'b0;
            case (st_r)
                ST_IDLE: begin
                    if (wr_ok && cmd_code_in == pmsb_pkg::CMD_STORE) begin
                        st_r <= ST_STORE;
                        cnt_r <= 32'(STORE_CYCLES - 1);
                        nvm_wr_r <= 1'b1;
                        busy_r <= 1'b1;
                    end else if (wr_ok &&
                                 cmd_code_in == pmsb_pkg::CMD_RESTORE) begin
                        st_r <= ST_RESTORE;
                        cnt_r <= 32'(RESTORE_CYCLES - 1);
                        busy_r <= 1'b1;
                    end
                end
                ST_STORE, ST_RESTORE: begin
                    if (cnt_r == 32'h0) begin
                        st_r <= ST_IDLE;
                        busy_r <= 1'b0;
                    end else begin
                        cnt_r <= cnt_r - 32'h1;
                    end
                end
                default: begin
                    st_r <= ST_IDLE;
                    busy_r <= 1'b0;
                end
            endcase
        end
    end

    // sticky flags: a new event wins over a same-cycle clear
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            st_vout_r <= 8'h00;
            st_iout_r <= 8'h00;
            st_in_r <= 8'h00;
            st_temp_r <= 8'h00;
            st_cml_r <= 8'h00;
        end else begin
            st_vout_r <= (is_clear ? 8'h00 : st_vout_r)
                | {events_in.ov_out, 7'h00};
            st_iout_r <= (is_clear ? 8'h00 : st_iout_r)
                | {events_in.oc_fault, 1'b0, events_in.oc_warn, 5'h00};
            st_in_r <= (is_clear ? 8'h00 : st_in_r)
                | {events_in.vin_ov, 2'b00, events_in.vin_uv,
                   events_in.low_vin_off, 3'b000};
            st_temp_r <= (is_clear ? 8'h00 : st_temp_r)
                | {events_in.ot_fault, events_in.ot_warn, 6'h00};
            st_cml_r <= (is_clear ? 8'h00 : st_cml_r)
                | {bad_cmd, bad_data, pec_err_in, 5'h00};
        end
    end

    // history ring of fault events with time stamp
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            hptr_r <= 5'h00;
        end else if (any_fault) begin
            hist_r[hptr_r] <= {time_in, st_vout_r | {events_in.ov_out,
                7'h00}, sum_ev};
            hptr_r <= (hptr_r == 5'(DEPTH - 1)) ? 5'h00 : hptr_r + 5'h01;
        end
    end

    wire [4:0] hsel = (hist_idx_in < 5'(DEPTH)) ? hist_idx_in : 5'h00;

    // outputs, all registered
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            rdata_r <= 16'h0000;
            rvalid_r <= 1'b0;
            ovcap_r <= pmsb_pkg::OV_RST;
            off_r <= 1'b0;
        end else begin
            rvalid_r <= cmd_rd_in;
            rdata_r <= cmd_rd_in ? rd_mux : rdata_r;
            ovcap_r <= ov_eff;
            off_r <= !par_r.oper[pmsb_pkg::OPER_ON_BIT];
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            hist_out <= 48'h0;
        end else begin
            hist_out <= hist_r[hsel];
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            output_on_out <= 1'b1;
            margin_out <= 2'b00;
        end else begin
            output_on_out <= par_r.oper[pmsb_pkg::OPER_ON_BIT];
            margin_out <= (par_r.oper[5:2] == pmsb_pkg::MARGIN_LOW) ? 2'b01
                : (par_r.oper[5:2] == pmsb_pkg::MARGIN_HIGH) ? 2'b10
                : 2'b00;
        end
    end

    assign rdata_out = rdata_r;
    assign rvalid_out = rvalid_r;
    assign busy_out = busy_r;
    assign ov_limit_eff_out = ovcap_r;
    assign nvm_wdata_out = par_r;
    assign nvm_wr_out = nvm_wr_r;

    // checks
    as_oc_a: assert property (@(posedge sys_clk_in)
        disable iff (!rstn_in)
        events_in.oc_fault |=> st_iout_r[7]) else $error("oc not latched");
    as_clear_a: assert property (@(posedge sys_clk_in)
        disable iff (!rstn_in)
        is_clear && !any_fault && !pec_err_in |=> st_temp_r == 8'h00)
        else $error("clear failed");
    unsup_zero_a: assert property (@(posedge sys_clk_in)
        disable iff (!rstn_in)
        st_vout_r[6:0] == 7'h00 && st_temp_r[5:0] == 6'h00)
        else $error("unsupported bit set");
    sticky_hold_a: assert property (@(posedge sys_clk_in)
        disable iff (!rstn_in)
        st_in_r[4] && !is_clear |=> st_in_r[4])
        else $error("flag dropped");
    bad_data_a: assert property (@(posedge sys_clk_in)
        disable iff (!rstn_in)
        bad_data |=> st_cml_r[6] && $stable(par_r))
        else $error("bad data accepted");
    ov_cap_a: assert property (@(posedge sys_clk_in)
        disable iff (!rstn_in)
        ##1 ovcap_r <= pmsb_pkg::OV_MAX && ovcap_r <= $past(par_r.ov_lim))
        else $error("ov cap above max");
    sequence s_restore_go;
        wr_ok && cmd_code_in == pmsb_pkg::CMD_RESTORE;
    endsequence
    restore_busy_a: assert property (@(posedge sys_clk_in)
        disable iff (!rstn_in)
        s_restore_go |=> busy_out [*2]) else $error("restore not busy");
    fmt_read_a: assert property (@(posedge sys_clk_in)
        disable iff (!rstn_in)
        cmd_rd_in && cmd_code_in == pmsb_pkg::CMD_FMT
        |=> rdata_out == 16'h0014) else $error("format value wrong");
    unsup_cmd_a: assert property (@(posedge sys_clk_in)
        disable iff (!rstn_in)
        is_w && cmd_code_in == pmsb_pkg::CMD_VSET |=> st_cml_r[7])
        else $error("unsupported code accepted");
    on_follow_a: assert property (@(posedge sys_clk_in)
        disable iff (!rstn_in)
        wr_ok && cmd_code_in == pmsb_pkg::CMD_OPER
        |=> ##1 output_on_out == $past(d[7], 2))
        else $error("on/off not applied");
    sequence s_store_go;
        wr_ok && cmd_code_in == pmsb_pkg::CMD_STORE;
    endsequence
    store_busy_a: assert property (@(posedge sys_clk_in)
        disable iff (!rstn_in)
        s_store_go |=> busy_out && nvm_wr_out ##1 busy_out && !nvm_wr_out)
        else $error("store not started");
    pec_latch_a: assert property (@(posedge sys_clk_in)
        disable iff (!rstn_in)
        pec_err_in |=> st_cml_r[5]) else $error("pec error not latched");
    cml_clear_a: assert property (@(posedge sys_clk_in)
        disable iff (!rstn_in)
        is_clear && !pec_err_in && !cmd_rd_in |=> st_cml_r == 8'h00)
        else $error("comm flags not cleared");
    unsup_rest_a: assert property (@(posedge sys_clk_in)
        disable iff (!rstn_in)
        st_cml_r[4:0] == 5'h00 && st_iout_r[6] == 1'b0
        && st_iout_r[4:0] == 5'h00 && st_in_r[6:5] == 2'b00
        && st_in_r[2:0] == 3'b000) else $error("unused status bit set");
    droop_max_a: assert property (@(posedge sys_clk_in)
        disable iff (!rstn_in)
        wr_ok && cmd_code_in == pmsb_pkg::CMD_DROOP
        |=> par_r.droop <= pmsb_pkg::DROOP_MAX) else $error("droop too big");
    hyst_keep_a: assert property (@(posedge sys_clk_in)
        disable iff (!rstn_in)
        wr_ok && cmd_code_in == pmsb_pkg::CMD_VINOFF
        |=> par_r.vin_off + pmsb_pkg::HYST_MIN <= par_r.vin_on)
        else $error("hysteresis gap lost");
    ov_range_a: assert property (@(posedge sys_clk_in)
        disable iff (!rstn_in)
        wr_ok && cmd_code_in == pmsb_pkg::CMD_OVLIM
        |=> par_r.ov_lim >= pmsb_pkg::OV_MIN
        && par_r.ov_lim <= pmsb_pkg::OV_MAX)
        else $error("ov limit out of range");
    margin_dec_a: assert property (@(posedge sys_clk_in)
        disable iff (!rstn_in)
        margin_out == 2'b01
        |-> $past(par_r.oper[5:2]) == pmsb_pkg::MARGIN_LOW)
        else $error("margin low without code");
    off_flag_a: assert property (@(posedge sys_clk_in)
        disable iff (!rstn_in)
        off_r == !$past(par_r.oper[pmsb_pkg::OPER_ON_BIT]))
        else $error("off flag wrong");
    hist_ptr_a: assert property (@(posedge sys_clk_in)
        disable iff (!rstn_in)
        hptr_r < 5'(DEPTH)) else $error("history pointer out of range");
    strap_hold_a: assert property (@(posedge sys_clk_in)
        disable iff (!rstn_in)
        !first_r |=> $stable(strap_r)) else $error("strap changed");
endmodule : pmsb_bank

// ===== pmsb_bank_bench.sv
// pmsb_bank_bench: self-checking bench for the status and command bank.
// assumes short store/restore counts of 20 and 10 cycles.
`timescale 1ns/1ps
module pmsb_bank_bench;
    localparam int ST_CYC = 20;
    localparam int RS_CYC = 10;
    // {code, data, readback, comm status, setpoint, effective ov limit}
    localparam logic [95:0] TAB [14] = '{
        96'h0028_01F4_01F4_0000_A000_D000, 96'h0028_01F5_01F4_0040_A000_D000,
        96'h0035_0137_0150_0040_A000_D000, 96'h0035_0171_0150_0040_A000_D000,
        96'h0036_0141_0120_0040_A000_D000, 96'h0036_0140_0140_0000_A000_D000,
        96'h0036_0151_0140_0040_A000_D000, 96'h0035_014F_0150_0040_A000_D000,
        96'h0040_AE65_D000_0040_A000_D000, 96'h0040_FFD8_D000_0040_A000_D000,
        96'h0040_FFD7_FFD7_0000_A000_D000, 96'h0040_AE66_AE66_0000_A000_AE66,
        96'h0040_AF00_AE66_0040_B000_AE66, 96'h0040_FFD7_FFD7_0000_7000_A000};
    // {operation byte, 5'h00, on, margin}
    localparam logic [15:0] OPT [4] = '{16'h0000, 16'h9805, 16'hA806,
        16'h8404};
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic pec_err = 1'b0;
    logic strap = 1'b1;
    logic [15:0] vset = 16'hA000;
    logic [31:0] tm = 32'h0000_0000;
    logic [4:0] idx = 5'h00;
    pmsb_pkg::pmsb_events_t ev = '0;
    pmsb_pkg::pmsb_params_t nvr = '0;
    logic [7:0] code;
    logic wr, rd, rvalid, busy, on, nvwr;
    logic [15:0] wdata, rdata, oveff;
    logic [1:0] margin;
    logic [47:0] hist;
    pmsb_pkg::pmsb_params_t nvw;
    int n_mismatch = 0;
    int n_compared = 0;
    int cyc = 0;
    always #50 sys_clk = ~sys_clk;
    pmsb_host host (.sys_clk_in(sys_clk), .busy_in(busy), .rvalid_in(rvalid),
        .rdata_in(rdata), .code_out(code), .wr_out(wr), .rd_out(rd),
        .wdata_out(wdata));
    pmsb_bank #(.STORE_CYCLES(ST_CYC), .RESTORE_CYCLES(RS_CYC)) dut (
        .sys_clk_in(sys_clk), .rstn_in(rstn), .cmd_code_in(code),
        .cmd_wr_in(wr), .cmd_rd_in(rd), .cmd_wdata_in(wdata),
        .pec_err_in(pec_err), .pol_strap_in(strap), .vout_set_in(vset),
        .events_in(ev), .time_in(tm), .nvm_rdata_in(nvr),
        .hist_idx_in(idx), .rdata_out(rdata), .rvalid_out(rvalid),
        .busy_out(busy), .output_on_out(on), .margin_out(margin),
        .ov_limit_eff_out(oveff), .nvm_wdata_out(nvw), .nvm_wr_out(nvwr),
        .hist_out(hist));
    task automatic conclude;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : conclude
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            n_mismatch++;
            conclude();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic rchk(input logic [7:0] c, input logic [15:0] e);
        logic [15:0] d;
        host.get(c, d);
        chk(d, e);
    endtask : rchk
    task automatic t_reset;
        rchk(pmsb_pkg::CMD_FMT, 16'h0014);
        rchk(pmsb_pkg::CMD_OPER, 16'h0080);
        rchk(pmsb_pkg::CMD_ONOFF, 16'h001F);
        for (int c = 8'h79; c <= 8'h7E; c++) begin
            rchk(8'(c), 16'h0000);
        end
        chk({15'h0000, on}, 16'h0001);
        chk(oveff, 16'hD000);
        host.put(pmsb_pkg::CMD_FMT, 16'h00FF);
        rchk(pmsb_pkg::CMD_FMT, 16'h0014);
        host.put(pmsb_pkg::CMD_ONOFF, 16'h0000);
        rchk(pmsb_pkg::CMD_ONOFF, 16'h0017);
        $display("test reset done");
    endtask : t_reset
    task automatic t_unsup;
        logic [7:0] codes [4] = '{8'h21, 8'h23, 8'h25, 8'h26};
        foreach (codes[i]) begin
            host.put(codes[i], 16'h0000);
            rchk(pmsb_pkg::CMD_ST_CML, 16'h0080);
            host.put(pmsb_pkg::CMD_CLEAR, 16'h0000);
            rchk(pmsb_pkg::CMD_ST_CML, 16'h0000);
        end
        @(posedge sys_clk);
        pec_err <= 1'b1;
        @(posedge sys_clk);
        pec_err <= 1'b0;
        rchk(pmsb_pkg::CMD_ST_CML, 16'h0020);
        host.put(pmsb_pkg::CMD_CLEAR, 16'h0000);
        $display("test unsupported done");
    endtask : t_unsup
    task automatic t_range;
        foreach (TAB[i]) begin
            @(posedge sys_clk);
            vset <= TAB[i][31:16];
            host.put(TAB[i][87:80], TAB[i][79:64]);
            rchk(TAB[i][87:80], TAB[i][63:48]);
            rchk(pmsb_pkg::CMD_ST_CML, TAB[i][47:32]);
            chk(oveff, TAB[i][15:0]);
            host.put(pmsb_pkg::CMD_CLEAR, 16'h0000);
        end
        @(posedge sys_clk);
        vset <= 16'hA000;
        $display("test range done");
    endtask : t_range
    task automatic t_oper;
        host.put(pmsb_pkg::CMD_OPER, 16'h0000);
        rchk(pmsb_pkg::CMD_SUMWORD, 16'h0040);
        foreach (OPT[i]) begin
            host.put(pmsb_pkg::CMD_OPER, {8'h00, OPT[i][15:8]});
            repeat (2) @(posedge sys_clk);
            #1;
            chk({13'h0000, on, margin}, {13'h0000, OPT[i][2:0]});
        end
        host.put(pmsb_pkg::CMD_OPER, 16'h0090);
        rchk(pmsb_pkg::CMD_OPER, 16'h0084);
        rchk(pmsb_pkg::CMD_ST_CML, 16'h0040);
        host.put(pmsb_pkg::CMD_CLEAR, 16'h0000);
        $display("test operation done");
    endtask : t_oper
    task automatic t_events;
        logic [15:0] d;
        @(posedge sys_clk);
        ev <= 8'hFF;
        tm <= 32'h1234ABCD;
        @(posedge sys_clk);
        ev <= 8'h00;
        rchk(pmsb_pkg::CMD_ST_VOUT, 16'h0080);
        rchk(pmsb_pkg::CMD_ST_IOUT, 16'h00A0);
        rchk(pmsb_pkg::CMD_ST_INPUT, 16'h0098);
        rchk(pmsb_pkg::CMD_ST_TEMP, 16'h00C0);
        host.get(pmsb_pkg::CMD_SUMWORD, d);
        chk(d, 16'h003C);
        chk(hist[47:32], 16'h1234);
        chk(hist[31:16], 16'hABCD);
        chk(hist[15:0], 16'h803C);
        host.put(pmsb_pkg::CMD_CLEAR, 16'h0000);
        rchk(pmsb_pkg::CMD_ST_TEMP, 16'h0000);
        $display("test events done");
    endtask : t_events
    task automatic wbusy(input int exp);
        int n;
        n = 0;
        while (busy === 1'b1 && n < 1000) begin
            n++;
            @(posedge sys_clk);
            #1;
        end
        chk(16'(n), 16'(exp));
    endtask : wbusy
    task automatic t_nvm;
        host.put(pmsb_pkg::CMD_DROOP, 16'h0064);
        host.put(pmsb_pkg::CMD_STORE, 16'h0000);
        chk({15'h0000, nvwr}, 16'h0001);
        chk(nvw.droop, 16'h0064);
        wbusy(ST_CYC);
        @(posedge sys_clk);
        nvr <= '{16'h0123, 16'h0160, 16'h0130, 16'hC000, 8'h80, 8'h1F};
        host.put(pmsb_pkg::CMD_RESTORE, 16'h0000);
        wbusy(RS_CYC);
        rchk(pmsb_pkg::CMD_DROOP, 16'h0123);
        rchk(pmsb_pkg::CMD_VINOFF, 16'h0130);
        $display("test store restore done");
    endtask : t_nvm
    // second reset in mid-run with the polarity strap low
    task automatic t_rerun;
        @(posedge sys_clk);
        rstn <= 1'b0;
        strap <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rchk(pmsb_pkg::CMD_ONOFF, 16'h001D);
        rchk(pmsb_pkg::CMD_OPER, 16'h0080);
        rchk(pmsb_pkg::CMD_DROOP, 16'h0000);
        chk(oveff, 16'hD000);
        $display("test second reset done");
    endtask : t_rerun
    initial begin
        repeat (6) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (2) @(posedge sys_clk);
        t_reset();
        t_unsup();
        t_range();
        t_oper();
        t_events();
        t_nvm();
        t_rerun();
        conclude();
    end
endmodule : pmsb_bank_bench

// ===== pmsb_host.sv
// pmsb_host: host-side command master for the status and command bank.
// assumes one-cycle strobes and a busy level from the bank.
`timescale 1ns/1ps
module pmsb_host (
    input wire logic sys_clk_in,
    input wire logic busy_in,
    input wire logic rvalid_in,
    input wire logic [15:0] rdata_in,
    output logic [7:0] code_out,
    output logic wr_out,
    output logic rd_out,
    output logic [15:0] wdata_out
);
    initial begin
        code_out = 8'hFF;
        wr_out = 1'b0;
        rd_out = 1'b0;
        wdata_out = 16'hFFFF;
    end
    // bounded, so a stuck busy shows as a mismatch and not a hang
    task automatic idle;
        int n;
        n = 0;
        while (busy_in !== 1'b0 && n < 10000) begin
            @(posedge sys_clk_in);
            #1;
            n++;
        end
    endtask : idle
    task automatic put(input logic [7:0] c, input logic [15:0] d);
        idle();
        @(posedge sys_clk_in);
        code_out <= c;
        wdata_out <= d;
        wr_out <= 1'b1;
        @(posedge sys_clk_in);
        wr_out <= 1'b0;
        // released lines show the inverse, never a stale match
        code_out <= ~c;
        wdata_out <= ~d;
        #1;
    endtask : put
    task automatic get(input logic [7:0] c, output logic [15:0] d);
        idle();
        @(posedge sys_clk_in);
        code_out <= c;
        rd_out <= 1'b1;
        @(posedge sys_clk_in);
        rd_out <= 1'b0;
        code_out <= ~c;
        #1;
        d = (rvalid_in === 1'b1) ? rdata_in : 16'hXXXX;
    endtask : get
endmodule : pmsb_host

// ===== pmsb_pkg.sv
// pmsb_pkg: command codes, field positions, reset values, timing counts
// for the power module status and command bank.
// assumes a 10 MHz system clock.
package pmsb_pkg;
    localparam int CLK_HZ = 10_000_000;
    // command codes
    localparam logic [7:0] CMD_OPER = 8'h01;
    localparam logic [7:0] CMD_ONOFF = 8'h02;
    localparam logic [7:0] CMD_CLEAR = 8'h03;
    localparam logic [7:0] CMD_STORE = 8'h11;
    localparam logic [7:0] CMD_RESTORE = 8'h12;
    localparam logic [7:0] CMD_FMT = 8'h20;
    localparam logic [7:0] CMD_VSET = 8'h21;
    localparam logic [7:0] CMD_VCAL = 8'h23;
    localparam logic [7:0] CMD_MHIGH = 8'h25;
    localparam logic [7:0] CMD_MLOW = 8'h26;
    localparam logic [7:0] CMD_DROOP = 8'h28;
    localparam logic [7:0] CMD_VINON = 8'h35;
    localparam logic [7:0] CMD_VINOFF = 8'h36;
    localparam logic [7:0] CMD_OVLIM = 8'h40;
    localparam logic [7:0] CMD_SUMWORD = 8'h79;
    localparam logic [7:0] CMD_ST_VOUT = 8'h7A;
    localparam logic [7:0] CMD_ST_IOUT = 8'h7B;
    localparam logic [7:0] CMD_ST_INPUT = 8'h7C;
    localparam logic [7:0] CMD_ST_TEMP = 8'h7D;
    localparam logic [7:0] CMD_ST_CML = 8'h7E;
    // reset values, write masks and format value
    localparam logic [7:0] OPER_RST = 8'h80;
    localparam logic [7:0] ONOFF_RST = 8'h1D;
    localparam logic [7:0] ONOFF_WMASK = 8'h0A;
    localparam logic [7:0] OPER_WMASK = 8'hFC;
    localparam logic [7:0] FMT_VAL = 8'h14;
    // field positions
    localparam int OPER_ON_BIT = 7;
    localparam int ONOFF_POL_BIT = 1;
    localparam logic [3:0] MARGIN_LOW = 4'h6;
    localparam logic [3:0] MARGIN_HIGH = 4'hA;
    // value limits, linear codes: droop in 0.1 mV/A, volts in 1/8 V,
    // ov limit in 2^-12 V
    localparam logic [15:0] DROOP_MAX = 16'h01F4;
    localparam logic [15:0] VINON_MIN = 16'h0138;
    localparam logic [15:0] VINON_MAX = 16'h0170;
    localparam logic [15:0] VINOFF_MIN = 16'h0100;
    localparam logic [15:0] VINOFF_MAX = 16'h0170;
    localparam logic [15:0] HYST_MIN = 16'h0010;
    localparam logic [15:0] OV_MIN = 16'hAE66;
    localparam logic [15:0] OV_MAX = 16'hFFD7;
    localparam logic [15:0] OV_MARGIN = 16'h3000;
    localparam logic [15:0] DROOP_RST = 16'h0000;
    localparam logic [15:0] VINON_RST = 16'h0150;
    localparam logic [15:0] VINOFF_RST = 16'h0120;
    localparam logic [15:0] OV_RST = 16'hD000;
    // timing
    localparam int STORE_MS = 500;
    localparam int RESTORE_MS = 200;
    localparam int STORE_CYC = STORE_MS * (CLK_HZ / 1000);
    localparam int RESTORE_CYC = RESTORE_MS * (CLK_HZ / 1000);
    localparam int HIST_DEPTH = 20;

    typedef struct packed {
        logic ov_out;
        logic oc_fault;
        logic oc_warn;
        logic vin_ov;
        logic vin_uv;
        logic low_vin_off;
        logic ot_fault;
        logic ot_warn;
    } pmsb_events_t;

    typedef struct packed {
        logic [15:0] droop;
        logic [15:0] vin_on;
        logic [15:0] vin_off;
        logic [15:0] ov_lim;
        logic [7:0] oper;
        logic [7:0] onoff;
    } pmsb_params_t;
endpackage : pmsb_pkg
